// ### pkg/lps_pkg.sv
/*
 Constants and types shared by the low-power wait/stop controller.
 Assumes a single system clock and a synchronous, active-high reset.
*/
// Contract
// - Wait instruction halts the core, keeps state.
// - Peripherals keep their clock during wait.
// - Wait leaves the active oscillator running.
// - Enabled peripheral interrupts end wait.
// - Reset in wait or stop restarts normally.
// - Wait exit resumes with no stabilisation delay.
// - Stop entered only with watchdog disabled.
// - Stop halts oscillator until interrupt or reset.
// - Stop exit waits for oscillator stabilisation.
// - Main-routine sleep: service interrupt, then continue.
// - Non-maskable sleep: just continue, stay non-maskable.
// - Interrupt-routine sleep, normal wake: continue routine.
// - Interrupt-routine sleep, non-maskable wake: service first.
// - Waking never changes the oscillator selection.
// - Active watchdog turns stop into wait.
// - Global enable low: only reset wakes.
// - Pending enabled interrupt skips wait or stop.
// - Global enable is bit 4 at C8h.
package lps_pkg;

	// Data address of the write-only interrupt option register.
	localparam logic [7:0] IRQ_OPTION_REG_ADDR = 8'hC8;
	// Bit position of the global interrupt enable in that register.
	localparam int GLOBAL_IRQ_ENABLE_BIT = 4;
	// Value of the interrupt option register after reset.
	localparam logic [7:0] IRQ_OPTION_REG_RST = 8'h00;
	// Default number of maskable interrupt request lines.
	localparam int N_IRQ_DEF = 4;
	// Number of low lines that are external pins and can wake from stop.
	localparam int N_EXT_IRQ = 2;
	// Default oscillator stabilisation delay in cycles after stop.
	localparam int STAB_CYCLES_DEF = 1024;

	// Controller states, one-hot.
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_WAIT = 4'h2,
		ST_STOP = 4'h4,
		ST_STAB = 4'h8
	} lps_state_t;

	// Processor context reported by the core; code 3 is illegal.
	typedef enum logic [1:0] {
		CTX_NORMAL = 2'h0,
		CTX_IRQ = 2'h1,
		CTX_NMI = 2'h2
	} lps_ctx_t;

endpackage

// ### core/lps_stab_timer.sv
/*
 Oscillator stabilisation timer for the low-power controller.
 Assumes run is held high for the whole delay and dropped after done.
*/
`timescale 1ns/1ns
module lps_stab_timer #(
	parameter int CYCLES = lps_pkg::STAB_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	output logic done
);
	import lps_pkg::*;

	// Counter width covers the full delay.
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	// Refuse a delay that could not count at least one cycle.
	generate
		if (CYCLES < 1) begin : g_bad
			$error("lps_stab_timer needs CYCLES of at least one");
		end
	endgenerate

	// Cycles spent so far in the current delay.
	logic [CW-1:0] cnt_r;

	// Count while running, restart from zero whenever idle.
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			// Idle or in reset, so the next delay starts from zero.
			cnt_r <= '0;
		end else begin
			// One more stabilisation cycle has gone by.
			cnt_r <= cnt_r + CW'(1);
		end
	end

	// Done rises in the last cycle of the delay.
	assign done = run && (cnt_r == LAST);

endmodule

// ### core/lps_ctrl.sv
/*
 Wait/stop low-power controller sitting between the instruction decoder,
 the core, the interrupt sources, the watchdog and the oscillator.
 Assumes the core reports its context and pending requests already
 masked by each peripheral's own enable; RST merges pin and watchdog reset.
*/
`timescale 1ns/1ns
module lps_ctrl #(
	parameter int N_IRQ = lps_pkg::N_IRQ_DEF,
	parameter int STAB_CYCLES = lps_pkg::STAB_CYCLES_DEF
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic WAIT_EXEC,
	input wire logic STOP_EXEC,
	input wire lps_pkg::lps_ctx_t CORE_CTX,
	input wire logic WDG_ACTIVE,
	input wire logic [N_IRQ-1:0] IRQ_PEND,
	input wire logic NMI_REQ,
	input wire logic IOR_WR,
	input wire logic [7:0] IOR_ADDR,
	input wire logic [7:0] IOR_DATA,
	output logic CORE_HALT,
	output logic OSC_RUN,
	output logic PERIPH_CLK_EN,
	output logic GLOBAL_IRQ_ENABLE,
	output logic SKIP,
	output logic RESUME,
	output logic RESUME_TAKE_IRQ,
	output lps_pkg::lps_state_t LP_STATE
);
	import lps_pkg::*;

	// Refuse fewer request lines than the external pins need.
	generate
		if (N_IRQ < N_EXT_IRQ) begin : g_bad
			$error("lps_ctrl needs N_IRQ of at least N_EXT_IRQ");
		end
	endgenerate

	// A wake-up needs the global enable; the non-maskable line counts too.
	function automatic logic wake_ok(input logic gen, input logic irq, input logic nmi);
		wake_ok = gen && (irq || nmi);
	endfunction

	// Present state and its next value.
	lps_state_t state_r;
	lps_state_t state_nxt;
	// Global interrupt enable held from the option register.
	logic gen_r;
	// Context captured when low power was entered.
	lps_ctx_t ctx_r;
	// Set when the waking request was the non-maskable one.
	logic nmi_wake_r;
	logic nmi_wake_nxt;
	// Registered outputs and their next values.
	logic halt_r;
	logic osc_run_r;
	logic skip_r;
	logic skip_nxt;
	logic resume_r;
	logic resume_nxt;
	logic take_r;
	logic take_nxt;
	// Decoded conditions used by the sequencer.
	logic sleep_req;
	logic pend_any;
	logic wake_any;
	logic wake_ext;
	logic stab_done;

	// Any sleep instruction executed by the core this cycle.
	assign sleep_req = WAIT_EXEC || STOP_EXEC;
	// An enabled request already waiting when the instruction runs.
	assign pend_any = wake_ok(gen_r, |IRQ_PEND, NMI_REQ);
	// Wake sources while the clock runs: every peripheral request.
	assign wake_any = wake_ok(gen_r, |IRQ_PEND, NMI_REQ);
	// Wake sources while stopped: only the external lines and the non-maskable request.
	assign wake_ext = wake_ok(gen_r, |IRQ_PEND[N_EXT_IRQ-1:0], NMI_REQ);

	// Stabilisation delay runs only in its own state.
	lps_stab_timer #(
		.CYCLES(STAB_CYCLES)
	) u_stab (
		.clk(CLK),
		.rst(RST),
		.run(state_r == ST_STAB),
		.done(stab_done)
	);

	// Decide how the core resumes from the captured context and wake kind.
	function automatic logic take_for(input lps_ctx_t ctx, input logic nmi);
		unique case (ctx)
			CTX_NORMAL: take_for = 1'b1;
			CTX_NMI: take_for = 1'b0;
			CTX_IRQ: take_for = nmi;
			default: take_for = 1'b0;
		endcase
	endfunction

	// Sequencer: entry, skip, wake and stabilisation.
	always_comb begin
		state_nxt = state_r;
		skip_nxt = 1'b0;
		resume_nxt = 1'b0;
		take_nxt = 1'b0;
		nmi_wake_nxt = nmi_wake_r;
		unique case (state_r)
			ST_RUN: begin
				if (sleep_req && pend_any) begin
					// The instruction is dropped and the core carries on.
					skip_nxt = 1'b1;
				end else if (STOP_EXEC && !WDG_ACTIVE) begin
					state_nxt = ST_STOP;
				end else if (sleep_req) begin
					// Stop with an active watchdog falls back to wait.
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (wake_any) begin
					// Clock never stopped, so resume on the next edge.
					state_nxt = ST_RUN;
					resume_nxt = 1'b1;
					take_nxt = take_for(ctx_r, NMI_REQ);
					nmi_wake_nxt = NMI_REQ;
				end
			end
			ST_STOP: begin
				if (wake_ext) begin
					// Restart the oscillator and hold the core meanwhile.
					state_nxt = ST_STAB;
					nmi_wake_nxt = NMI_REQ;
				end
			end
			ST_STAB: begin
				if (stab_done) begin
					state_nxt = ST_RUN;
					resume_nxt = 1'b1;
					take_nxt = take_for(ctx_r, nmi_wake_r);
				end
			end
		endcase
	end

	// State register; reset always returns to the run state.
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Context is captured as the core enters low power.
	always_ff @(posedge CLK) begin
		if (RST) begin
			ctx_r <= CTX_NORMAL;
		end else if (state_r == ST_RUN && state_nxt != ST_RUN) begin
			ctx_r <= CORE_CTX;
		end
	end

	// Kind of the waking request, kept through stabilisation.
	always_ff @(posedge CLK) begin
		if (RST) begin
			nmi_wake_r <= 1'b0;
		end else begin
			nmi_wake_r <= nmi_wake_nxt;
		end
	end

	// Global enable follows writes to the option register.
	always_ff @(posedge CLK) begin
		if (RST) begin
			gen_r <= IRQ_OPTION_REG_RST[GLOBAL_IRQ_ENABLE_BIT];
		end else if (IOR_WR && IOR_ADDR == IRQ_OPTION_REG_ADDR) begin
			gen_r <= IOR_DATA[GLOBAL_IRQ_ENABLE_BIT];
		end
	end

	// Core halt is held in every state but run.
	always_ff @(posedge CLK) begin
		if (RST) begin
			halt_r <= 1'b0;
		end else begin
			halt_r <= (state_nxt != ST_RUN);
		end
	end

	// Oscillator stops only in the stop state; wait keeps it going.
	always_ff @(posedge CLK) begin
		if (RST) begin
			osc_run_r <= 1'b1;
		end else begin
			osc_run_r <= (state_nxt != ST_STOP);
		end
	end

	// One-cycle answers towards the core.
	always_ff @(posedge CLK) begin
		if (RST) begin
			skip_r <= 1'b0;
			resume_r <= 1'b0;
			take_r <= 1'b0;
		end else begin
			skip_r <= skip_nxt;
			resume_r <= resume_nxt;
			take_r <= take_nxt;
		end
	end

	// Outputs come straight from the registers above.
	assign CORE_HALT = halt_r;
	assign OSC_RUN = osc_run_r;
	// Peripherals are clocked whenever the oscillator runs.
	assign PERIPH_CLK_EN = osc_run_r;
	// Oscillator selection is owned by the program; nothing here drives it.
	assign GLOBAL_IRQ_ENABLE = gen_r;
	assign SKIP = skip_r;
	assign RESUME = resume_r;
	assign RESUME_TAKE_IRQ = take_r;
	assign LP_STATE = state_r;

	// Checks of the sequencer behaviour.
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	// Cycles spent in stabilisation, read only by a check.
	int stab_len;
	always_ff @(posedge CLK) begin
		if (RST) begin
			stab_len <= 0;
		end else if (state_r == ST_STAB) begin
			stab_len <= stab_len + 1;
		end else begin
			stab_len <= 0;
		end
	end

	// A sleep instruction met in run with nothing pending.
	sequence s_sleep_clear;
		state_r == ST_RUN && sleep_req && !pend_any;
	endsequence

	// Wake from stop followed by the stabilisation state.
	sequence s_stop_wake;
		state_r == ST_STOP && wake_ext ##1 state_r == ST_STAB;
	endsequence

	a_skip_pending: assert property (
		(state_r == ST_RUN && sleep_req && pend_any) |=> (state_r == ST_RUN && SKIP))
		else $error("pending request did not skip the sleep instruction");

	a_stop_watchdog: assert property (
		(s_sleep_clear and (STOP_EXEC && WDG_ACTIVE)) |=> (state_r == ST_WAIT && OSC_RUN))
		else $error("stop with watchdog active did not become wait");

	a_stop_entry: assert property (
		(s_sleep_clear and (STOP_EXEC && !WDG_ACTIVE)) |=> (state_r == ST_STOP && !OSC_RUN))
		else $error("stop did not halt the oscillator");

	a_wait_clocks: assert property (
		(state_r == ST_WAIT) |-> (OSC_RUN && PERIPH_CLK_EN && CORE_HALT))
		else $error("wait lost the clock or released the core");

	a_wait_wake_fast: assert property (
		(state_r == ST_WAIT && wake_any) |=> (state_r == ST_RUN && RESUME && !CORE_HALT))
		else $error("wait exit was delayed");

	a_gen_blocks: assert property (
		(state_r != ST_RUN && state_r != ST_STAB && !gen_r) |=> $stable(state_r))
		else $error("woke up with global enable low");

	a_stab_hold: assert property (
		s_stop_wake |-> (CORE_HALT && !RESUME) [*2])
		else $error("core released too early after stop");

	a_stab_length: assert property (
		(state_r == ST_STAB && state_nxt == ST_RUN) |-> (stab_len == STAB_CYCLES - 1))
		else $error("stabilisation delay has the wrong length");

	a_nmi_ctx_next: assert property (
		(RESUME && ctx_r == CTX_NMI) |-> !RESUME_TAKE_IRQ)
		else $error("non-maskable context took an interrupt on wake");

	a_normal_take: assert property (
		(RESUME && ctx_r == CTX_NORMAL) |-> RESUME_TAKE_IRQ)
		else $error("main routine wake did not service the interrupt");

	a_irq_ctx_take: assert property (
		(RESUME && ctx_r == CTX_IRQ) |-> (RESUME_TAKE_IRQ == nmi_wake_r))
		else $error("interrupt context wake resumed the wrong way");

	a_gen_write: assert property (
		(IOR_WR && IOR_ADDR == IRQ_OPTION_REG_ADDR) |=>
			(GLOBAL_IRQ_ENABLE == $past(IOR_DATA[GLOBAL_IRQ_ENABLE_BIT])))
		else $error("global enable did not follow the option write");

	a_reset_run: assert property (disable iff (1'b0)
		RST |=> (state_r == ST_RUN && OSC_RUN && !CORE_HALT))
		else $error("reset did not return to run");

endmodule

// ### tb/lps_core_model.sv
/*
 Behavioural core that issues wait and stop instructions on request.
 Assumes bench requests change shortly after a rising clock edge.
*/
`timescale 1ns/1ns
module lps_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic do_wait,
	input wire logic do_stop,
	input wire logic core_halt,
	output logic wait_exec,
	output logic stop_exec
);
	// The program picks its oscillator before any wait; this model keeps one selection.
	// A halted core runs no code, so it never issues a sleep instruction then.
	always_ff @(posedge clk) begin
		if (rst) begin
			wait_exec <= 1'b0;
			stop_exec <= 1'b0;
		end else begin
			wait_exec <= do_wait && !core_halt;
			stop_exec <= do_stop && !core_halt;
		end
	end
endmodule

// ### tb/tb_top.sv
/*
 Self-checking bench for the low-power wait/stop controller.
 Assumes the core model file and the controller package are compiled first.
*/
`timescale 1ns/1ns
module tb_top;
	import lps_pkg::*;
	localparam int STAB = 4; // Short stabilisation delay keeps the run brief.
	logic clk, rst, do_wait, do_stop, wait_exec, stop_exec, wdg, nmi, ior_wr;
	logic core_halt, osc_run, periph_en, gen, skip, resume, take;
	logic [3:0] irq; // Maskable requests towards the controller.
	logic [7:0] ior_addr, ior_data;
	lps_ctx_t core_ctx; // Context the core reports.
	lps_state_t lp_state; // Observed controller state.
	int err_count = 0;
	int check_count = 0;

	lps_core_model core (.clk(clk), .rst(rst), .do_wait(do_wait), .do_stop(do_stop),
		.core_halt(core_halt), .wait_exec(wait_exec), .stop_exec(stop_exec));

	lps_ctrl #(.N_IRQ(4), .STAB_CYCLES(STAB)) DUT (.CLK(clk), .RST(rst),
		.WAIT_EXEC(wait_exec), .STOP_EXEC(stop_exec), .CORE_CTX(core_ctx),
		.WDG_ACTIVE(wdg), .IRQ_PEND(irq), .NMI_REQ(nmi), .IOR_WR(ior_wr),
		.IOR_ADDR(ior_addr), .IOR_DATA(ior_data), .CORE_HALT(core_halt),
		.OSC_RUN(osc_run), .PERIPH_CLK_EN(periph_en), .GLOBAL_IRQ_ENABLE(gen),
		.SKIP(skip), .RESUME(resume), .RESUME_TAKE_IRQ(take), .LP_STATE(lp_state));

	// The clock toggles every half period of 20 ns.
	always #20 clk = ~clk;

	// Compares one value and counts the outcome.
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Moves to just after the next rising edge.
	task step;
		@(posedge clk);
		#1;
	endtask

	// Writes one data-space location, then leaves an idle cycle.
	task wr(input logic [7:0] a, input logic [7:0] d);
		ior_wr = 1'b1;
		ior_addr = a;
		ior_data = d;
		step();
		ior_wr = 1'b0;
		step();
	endtask

	// Asks the core for a sleep instruction and waits until it is taken.
	task sleep(input logic stp);
		do_stop = stp;
		do_wait = !stp;
		step();
		do_stop = 1'b0;
		do_wait = 1'b0;
		step();
	endtask

	// Sleeps, wakes by the given requests and judges the resume.
	task nap(input logic stp, input lps_ctx_t ctx, input logic w, input logic [3:0] ir,
		input logic nm, input lps_state_t st, input logic tk);
		int n;
		core_ctx = ctx;
		wdg = w;
		sleep(stp);
		chk(lp_state, st);
		chk({core_halt, osc_run, periph_en}, {1'b1, st != ST_STOP, st != ST_STOP});
		if (st == ST_STOP) begin
			irq = 4'h4;
			repeat (3) step();
			chk(lp_state, ST_STOP);
		end
		irq = ir;
		nmi = nm;
		n = 0;
		step();
		while (resume !== 1'b1 && n < 50) begin
			n++;
			step();
		end
		chk(8'(n), 8'((st == ST_STOP) ? STAB : 0));
		chk({resume, take, core_halt, lp_state}, {1'b1, tk, 1'b0, ST_RUN});
		irq = 4'h0;
		nmi = 1'b0;
		step();
		chk({resume, osc_run}, 2'b01);
	endtask

	// Reset values and writes to the interrupt option register.
	task t_gen;
		chk({gen, osc_run, periph_en, core_halt, skip, resume, take}, 7'h30);
		chk(lp_state, ST_RUN);
		wr(8'hC9, 8'h10);
		chk(gen, 1'b0);
		wr(8'hC8, 8'hEF);
		chk(gen, 1'b0);
		wr(8'hC8, 8'h10);
		chk(gen, 1'b1);
		$display("t_gen finished");
	endtask

	// Wake paths for every context and both sleep kinds.
	task t_wake;
		nap(1'b0, CTX_NORMAL, 1'b0, 4'h4, 1'b0, ST_WAIT, 1'b1);
		nap(1'b1, CTX_NMI, 1'b0, 4'h2, 1'b0, ST_STOP, 1'b0);
		nap(1'b1, CTX_IRQ, 1'b1, 4'h0, 1'b1, ST_WAIT, 1'b1);
		nap(1'b0, CTX_IRQ, 1'b0, 4'h8, 1'b0, ST_WAIT, 1'b0);
		nap(1'b1, CTX_NORMAL, 1'b0, 4'h1, 1'b0, ST_STOP, 1'b1);
		$display("t_wake finished");
	endtask

	// A pending enabled request drops the instruction.
	task t_skip;
		irq = 4'h8;
		sleep(1'b0);
		chk({skip, core_halt, lp_state}, {1'b1, 1'b0, ST_RUN});
		irq = 4'h0;
		step();
		chk(skip, 1'b0);
		$display("t_skip finished");
	endtask

	// With the global enable low only reset leaves wait or stop.
	task t_gen_off;
		core_ctx = CTX_NORMAL;
		wdg = 1'b0;
		wr(8'hC8, 8'h00);
		for (int i = 0; i < 2; i++) begin
			sleep(i[0]);
			irq = 4'hF;
			nmi = 1'b1;
			repeat (5) step();
			chk({resume, lp_state}, {1'b0, i[0] ? ST_STOP : ST_WAIT});
			rst = 1'b1;
			step();
			rst = 1'b0;
			chk({lp_state, core_halt, osc_run, gen}, {ST_RUN, 3'b010});
		end
		irq = 4'h0;
		nmi = 1'b0;
		$display("t_gen_off finished");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task test_done;
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Main sequence: reset for four cycles, then the scenarios.
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{do_wait, do_stop, wdg, nmi, ior_wr} = 5'h00;
		irq = 4'h0;
		ior_addr = 8'h00;
		ior_data = 8'h00;
		core_ctx = CTX_NORMAL;
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		step();
		t_gen();
		t_wake();
		t_skip();
		t_gen_off();
		test_done();
	end

	// Cuts a hang short well after the scenarios should have ended.
	initial begin
		#80000;
		err_count++;
		test_done();
	end
endmodule
